// ---- logic/alu_ext_pkg.sv ----
package alu_ext_pkg;

  // ==========================================================
  // Major opcodes and function fields
  // ==========================================================
  localparam logic [6:0] OPC_GENERAL   = 7'h2b;
  localparam logic [6:0] OPC_IMM_SHIFT = 7'h5b;
  localparam logic [6:0] OPC_BRANCH    = 7'h0b;
  localparam logic [2:0] F3_GENERAL    = 3'h3;
  localparam logic [2:0] F3_ADD_CONST  = 3'h2;
  localparam logic [2:0] F3_SUB_CONST  = 3'h3;
  localparam logic [2:0] F3_BRANCH_EQ  = 3'h6;
  localparam logic [2:0] F3_BRANCH_NE  = 3'h7;

  localparam logic [6:0] F7_ABS        = 7'h28;
  localparam logic [6:0] F7_SLE_S      = 7'h29;
  localparam logic [6:0] F7_SLE_U      = 7'h2a;
  localparam logic [6:0] F7_MIN_S      = 7'h2b;
  localparam logic [6:0] F7_MIN_U      = 7'h2c;
  localparam logic [6:0] F7_MAX_S      = 7'h2d;
  localparam logic [6:0] F7_MAX_U      = 7'h2e;
  localparam logic [6:0] F7_EXTH_S     = 7'h2f;
  localparam logic [6:0] F7_EXTH_Z     = 7'h30;
  localparam logic [6:0] F7_EXTB_S     = 7'h31;
  localparam logic [6:0] F7_EXTB_Z     = 7'h32;
  localparam logic [6:0] F7_CLIP_S_C   = 7'h38;
  localparam logic [6:0] F7_CLIP_U_C   = 7'h39;
  localparam logic [6:0] F7_CLIP_S_R   = 7'h3a;
  localparam logic [6:0] F7_CLIP_U_R   = 7'h3b;
  localparam logic [3:0] F7_ACC_GROUP  = 4'h8;

  // ==========================================================
  // Field positions inside the instruction word
  // ==========================================================
  localparam int FUNCT7_LSB  = 25;
  localparam int RS2_LSB     = 20;
  localparam int FUNCT3_LSB  = 12;
  localparam int RD_LSB      = 7;
  localparam int SHAMT_LSB   = 25;
  localparam int VAR_ROUND   = 31;
  localparam int VAR_LOGIC   = 30;
  localparam int ACC_SUB     = 2;
  localparam int ACC_ROUND   = 1;
  localparam int ACC_LOGIC   = 0;

  // ==========================================================
  // Reset values
  // ==========================================================
  localparam logic [31:0] DATA_RST = 32'h0000_0000;
  localparam logic [4:0]  ADDR_RST = 5'h00;

  // ==========================================================
  // Decoded operation
  // ==========================================================
  typedef enum logic [4:0] {
    NOT_MINE, ILLEGAL_OP, ABSOLUTE_VALUE_OP, SET_LE_SIGNED, SET_LE_UNSIGNED,
    MINIMUM_SIGNED, MINIMUM_UNSIGNED, MAXIMUM_SIGNED, MAXIMUM_UNSIGNED,
    HALF_SIGN_EXTEND, HALF_ZERO_EXTEND, BYTE_SIGN_EXTEND, BYTE_ZERO_EXTEND,
    SATURATE_SIGNED_CONST, SATURATE_UNSIGNED_CONST, SATURATE_SIGNED_REG,
    SATURATE_UNSIGNED_REG, ACC_SHIFT_REG, ADD_CONST_SHIFT, SUB_CONST_SHIFT,
    BRANCH_EQ_CONST, BRANCH_NE_CONST
  } op_t;

endpackage : alu_ext_pkg

// ---- logic/round_shift.sv ----
// ==========================================================
// Add or subtract, optional rounding, right shift
// ==========================================================
module round_shift (
  input  wire logic [31:0] op_a,
  input  wire logic [31:0] op_b,
  input  wire logic        sub,
  input  wire logic        round,
  input  wire logic        arith,
  input  wire logic [4:0]  amount,
  output logic      [31:0] result
);
  logic [31:0] sum;
  logic [31:0] round_term;
  logic [31:0] total;

  // Sum wraps at 32 bits, as the destination does
  always_comb begin
    sum = sub ? op_a - op_b : op_a + op_b;
    round_term = 32'h0000_0000;
    // RULE7 zero amount rounding
    if (round && amount != 5'h00) begin
      round_term = 32'h0000_0001 << (amount - 5'h01);
    end
    total  = sum + round_term;
    result = arith ? 32'($signed(total) >>> amount) : total >> amount;
  end

endmodule : round_shift

// ---- logic/alu_ext_unit.sv ----
// Overview of operation
// RULE1 - Register add arithmetic: (dest + src1) shifted right arithmetically by src2[4:0].
// RULE2 - Register add logical: (dest + src1) shifted right logically by src2[4:0].
// RULE3 - Rounding register adds add two to (amount minus one) before the shift.
// RULE4 - Register subtract arithmetic: (dest - src1) shifted right arithmetically.
// RULE5 - Register subtract logical: (dest - src1) shifted right logically.
// RULE6 - Rounding register subtracts add two to (amount minus one) before shifting.
// RULE7 - Zero shift amount gives a zero rounding term.
// RULE8 - Funct7 1000000..1000111 select the eight register-amount shift operations.
// RULE9 - Funct7 0101000..0110010 select abs, compares, min, max and extensions.
// RULE10 - Funct7 0111000/0111001 are clips bounded by a five-bit constant.
// RULE11 - Funct7 0111010/0111011 are clips bounded by source register two.
// RULE12 - Opcode 1011011 funct3 010 is add with constant shift, variant in 31:30.
// RULE13 - Funct3 011 under that opcode is subtract with constant shift.
// RULE14 - Branch-equal-constant jumps to pc plus doubled offset when src1 matches.
// RULE15 - Branch-not-equal-constant jumps when src1 differs, else falls through.
// RULE16 - The five-bit compare constant is sign-extended before comparing.
// RULE17 - Branch-equal-constant uses funct3 110, opcode 0001011, scattered offset bits.
// RULE18 - Branch-not-equal-constant uses funct3 111 with the same layout.
// RULE19 - Absolute value negates a negative source, else passes it.
// RULE20 - Signed forms compare signed, unsigned forms compare unsigned.
// RULE21 - Register clips saturate to [-(bound+1), bound] or [0, bound].
// RULE22 - Unmatched encodings under these opcodes are illegal and write nothing.
module alu_ext_unit (
  input  wire logic        clock,
  input  wire logic        sys_rst,
  input  wire logic        instr_valid,
  input  wire logic [31:0] instr,
  input  wire logic [31:0] pc,
  input  wire logic [31:0] rs1_value,
  input  wire logic [31:0] rs2_value,
  input  wire logic [31:0] rd_value,
  output logic             wb_valid_q,
  output logic      [4:0]  wb_addr_q,
  output logic      [31:0] wb_data_q,
  output logic             illegal_q,
  output logic             branch_valid_q,
  output logic             branch_taken_q,
  output logic      [31:0] branch_target_q
);

  // ==========================================================
  // Instruction fields
  // ==========================================================
  logic [6:0]  opcode;
  logic [2:0]  funct3;
  logic [6:0]  funct7;
  logic [4:0]  src2_field;
  logic        src2_zero;
  alu_ext_pkg::op_t op_d;

  assign opcode     = instr[6:0];
  assign funct3     = instr[alu_ext_pkg::FUNCT3_LSB +: 3];
  assign funct7     = instr[alu_ext_pkg::FUNCT7_LSB +: 7];
  assign src2_field = instr[alu_ext_pkg::RS2_LSB +: 5];
  // Single-operand forms must carry a zero second-source field
  assign src2_zero  = (src2_field == 5'h00);

  // ==========================================================
  // Decoder
  // ==========================================================
  // RULE9 general group decode
  always_comb begin
    op_d = alu_ext_pkg::NOT_MINE;
    case (opcode)
      alu_ext_pkg::OPC_GENERAL: begin
        op_d = alu_ext_pkg::ILLEGAL_OP;
        if (funct3 == alu_ext_pkg::F3_GENERAL) begin
          case (funct7)
            alu_ext_pkg::F7_ABS:
              op_d = src2_zero ? alu_ext_pkg::ABSOLUTE_VALUE_OP : alu_ext_pkg::ILLEGAL_OP;
            alu_ext_pkg::F7_SLE_S:    op_d = alu_ext_pkg::SET_LE_SIGNED;
            alu_ext_pkg::F7_SLE_U:    op_d = alu_ext_pkg::SET_LE_UNSIGNED;
            alu_ext_pkg::F7_MIN_S:    op_d = alu_ext_pkg::MINIMUM_SIGNED;
            alu_ext_pkg::F7_MIN_U:    op_d = alu_ext_pkg::MINIMUM_UNSIGNED;
            alu_ext_pkg::F7_MAX_S:    op_d = alu_ext_pkg::MAXIMUM_SIGNED;
            alu_ext_pkg::F7_MAX_U:    op_d = alu_ext_pkg::MAXIMUM_UNSIGNED;
            alu_ext_pkg::F7_EXTH_S:
              op_d = src2_zero ? alu_ext_pkg::HALF_SIGN_EXTEND : alu_ext_pkg::ILLEGAL_OP;
            alu_ext_pkg::F7_EXTH_Z:
              op_d = src2_zero ? alu_ext_pkg::HALF_ZERO_EXTEND : alu_ext_pkg::ILLEGAL_OP;
            alu_ext_pkg::F7_EXTB_S:
              op_d = src2_zero ? alu_ext_pkg::BYTE_SIGN_EXTEND : alu_ext_pkg::ILLEGAL_OP;
            alu_ext_pkg::F7_EXTB_Z:
              op_d = src2_zero ? alu_ext_pkg::BYTE_ZERO_EXTEND : alu_ext_pkg::ILLEGAL_OP;
            // RULE10 constant bound clips
            alu_ext_pkg::F7_CLIP_S_C: op_d = alu_ext_pkg::SATURATE_SIGNED_CONST;
            alu_ext_pkg::F7_CLIP_U_C: op_d = alu_ext_pkg::SATURATE_UNSIGNED_CONST;
            // RULE11 register bound clips
            alu_ext_pkg::F7_CLIP_S_R: op_d = alu_ext_pkg::SATURATE_SIGNED_REG;
            alu_ext_pkg::F7_CLIP_U_R: op_d = alu_ext_pkg::SATURATE_UNSIGNED_REG;
            default: begin
              // RULE8 register shift family
              if (funct7[6:3] == alu_ext_pkg::F7_ACC_GROUP) begin
                op_d = alu_ext_pkg::ACC_SHIFT_REG;
              end
            end
          endcase
        end
      end
      alu_ext_pkg::OPC_IMM_SHIFT: begin
        // RULE12 add constant shift
        if (funct3 == alu_ext_pkg::F3_ADD_CONST) begin
          op_d = alu_ext_pkg::ADD_CONST_SHIFT;
        // RULE13 sub constant shift
        end else if (funct3 == alu_ext_pkg::F3_SUB_CONST) begin
          op_d = alu_ext_pkg::SUB_CONST_SHIFT;
        end else begin
          op_d = alu_ext_pkg::ILLEGAL_OP;
        end
      end
      alu_ext_pkg::OPC_BRANCH: begin
        // RULE17 equal branch decode
        if (funct3 == alu_ext_pkg::F3_BRANCH_EQ) begin
          op_d = alu_ext_pkg::BRANCH_EQ_CONST;
        // RULE18 not-equal branch decode
        end else if (funct3 == alu_ext_pkg::F3_BRANCH_NE) begin
          op_d = alu_ext_pkg::BRANCH_NE_CONST;
        end else begin
          op_d = alu_ext_pkg::ILLEGAL_OP;
        end
      end
      default: op_d = alu_ext_pkg::NOT_MINE;
    endcase
  end

  // ==========================================================
  // Shared add/subtract and shift path
  // ==========================================================
  logic        is_acc;
  logic [31:0] sh_a;
  logic [31:0] sh_b;
  logic        sh_sub;
  logic        sh_round;
  logic        sh_arith;
  logic [4:0]  sh_amount;
  logic [31:0] sh_result;

  assign is_acc = (op_d == alu_ext_pkg::ACC_SHIFT_REG);

  // One shifter serves both families; operands, amount and the sub/round/logical bits all move
  always_comb begin
    if (is_acc) begin
      // RULE1 dest plus src1
      sh_a      = rd_value;
      sh_b      = rs1_value;
      sh_amount = rs2_value[4:0];
      // RULE4 subtract variants
      sh_sub    = funct7[alu_ext_pkg::ACC_SUB];
      // RULE3 rounding variants
      sh_round  = funct7[alu_ext_pkg::ACC_ROUND];
      // RULE2 logical variants
      sh_arith  = !funct7[alu_ext_pkg::ACC_LOGIC];
    end else begin
      sh_a      = rs1_value;
      sh_b      = rs2_value;
      sh_amount = instr[alu_ext_pkg::SHAMT_LSB +: 5];
      sh_sub    = (op_d == alu_ext_pkg::SUB_CONST_SHIFT);
      sh_round  = instr[alu_ext_pkg::VAR_ROUND];
      sh_arith  = !instr[alu_ext_pkg::VAR_LOGIC];
    end
  end

  // RULE6 rounding subtracts too
  round_shift shifter (
    .op_a   (sh_a),
    .op_b   (sh_b),
    .sub    (sh_sub),
    .round  (sh_round),
    .arith  (sh_arith),
    .amount (sh_amount),
    .result (sh_result)
  );

  // ==========================================================
  // Clip bounds
  // ==========================================================
  logic [31:0] const_hi;
  logic [31:0] clip_hi;
  logic [31:0] clip_lo;

  // Zero bound collapses the range to [-1, 0]
  assign const_hi = (src2_field == 5'h00) ? 32'h0000_0000 :
                    (32'h0000_0001 << (src2_field - 5'h01)) - 32'h0000_0001;
  assign clip_hi  = (op_d == alu_ext_pkg::SATURATE_SIGNED_REG ||
                     op_d == alu_ext_pkg::SATURATE_UNSIGNED_REG) ? rs2_value : const_hi;
  // -(hi + 1) is the bitwise complement
  assign clip_lo  = ~clip_hi;

  // ==========================================================
  // Result select
  // ==========================================================
  logic [31:0] result_d;
  logic        lt_s;
  logic        lt_u;

  // RULE20 signed and unsigned compares
  assign lt_s = $signed(rs1_value) < $signed(rs2_value);
  assign lt_u = rs1_value < rs2_value;

  always_comb begin
    result_d = alu_ext_pkg::DATA_RST;
    case (op_d)
      // RULE19 absolute value
      alu_ext_pkg::ABSOLUTE_VALUE_OP:
        result_d = rs1_value[31] ? 32'h0000_0000 - rs1_value : rs1_value;
      alu_ext_pkg::SET_LE_SIGNED:    result_d = {31'h0, lt_s || rs1_value == rs2_value};
      alu_ext_pkg::SET_LE_UNSIGNED:  result_d = {31'h0, lt_u || rs1_value == rs2_value};
      alu_ext_pkg::MINIMUM_SIGNED:   result_d = lt_s ? rs1_value : rs2_value;
      alu_ext_pkg::MINIMUM_UNSIGNED: result_d = lt_u ? rs1_value : rs2_value;
      alu_ext_pkg::MAXIMUM_SIGNED:   result_d = lt_s ? rs2_value : rs1_value;
      alu_ext_pkg::MAXIMUM_UNSIGNED: result_d = lt_u ? rs2_value : rs1_value;
      alu_ext_pkg::HALF_SIGN_EXTEND: result_d = {{16{rs1_value[15]}}, rs1_value[15:0]};
      alu_ext_pkg::HALF_ZERO_EXTEND: result_d = {16'h0000, rs1_value[15:0]};
      alu_ext_pkg::BYTE_SIGN_EXTEND: result_d = {{24{rs1_value[7]}}, rs1_value[7:0]};
      alu_ext_pkg::BYTE_ZERO_EXTEND: result_d = {24'h00_0000, rs1_value[7:0]};
      // RULE21 signed saturation
      alu_ext_pkg::SATURATE_SIGNED_CONST, alu_ext_pkg::SATURATE_SIGNED_REG: begin
        if ($signed(rs1_value) <= $signed(clip_lo)) begin
          result_d = clip_lo;
        end else if ($signed(rs1_value) >= $signed(clip_hi)) begin
          result_d = clip_hi;
        end else begin
          result_d = rs1_value;
        end
      end
      // RULE21 unsigned saturation
      alu_ext_pkg::SATURATE_UNSIGNED_CONST, alu_ext_pkg::SATURATE_UNSIGNED_REG: begin
        if ($signed(rs1_value) <= $signed(32'h0000_0000)) begin
          result_d = 32'h0000_0000;
        end else if (rs1_value >= clip_hi) begin
          result_d = clip_hi;
        end else begin
          result_d = rs1_value;
        end
      end
      alu_ext_pkg::ACC_SHIFT_REG, alu_ext_pkg::ADD_CONST_SHIFT,
      alu_ext_pkg::SUB_CONST_SHIFT:  result_d = sh_result;
      default:                       result_d = alu_ext_pkg::DATA_RST;
    endcase
  end

  // ==========================================================
  // Branch compare and target
  // ==========================================================
  logic        is_branch;
  logic [31:0] cmp_const;
  logic [31:0] br_offset;
  logic        br_equal;

  assign is_branch = (op_d == alu_ext_pkg::BRANCH_EQ_CONST) ||
                     (op_d == alu_ext_pkg::BRANCH_NE_CONST);
  // RULE16 sign-extended compare constant
  assign cmp_const = {{27{src2_field[4]}}, src2_field};
  // RULE17 scattered offset, doubled
  assign br_offset = {{19{instr[31]}}, instr[31], instr[7], instr[30:25], instr[11:8], 1'b0};
  assign br_equal  = (rs1_value == cmp_const);

  // ==========================================================
  // Writeback registers
  // ==========================================================
  logic writes_d;

  // RULE22 only legal ALU ops write
  assign writes_d = instr_valid && !is_branch &&
                    op_d != alu_ext_pkg::NOT_MINE && op_d != alu_ext_pkg::ILLEGAL_OP;

  // Write strobe and destination
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      wb_valid_q <= 1'b0;
      wb_addr_q  <= alu_ext_pkg::ADDR_RST;
    end else begin
      wb_valid_q <= writes_d;
      wb_addr_q  <= instr[alu_ext_pkg::RD_LSB +: 5];
    end
  end

  // Data is held when nothing is written, to save toggling
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      wb_data_q <= alu_ext_pkg::DATA_RST;
    end else if (writes_d) begin
      wb_data_q <= result_d;
    end
  end

  // RULE22 illegal flag
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      illegal_q <= 1'b0;
    end else begin
      illegal_q <= instr_valid && (op_d == alu_ext_pkg::ILLEGAL_OP);
    end
  end

  // Branch resolution to fetch
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      branch_valid_q  <= 1'b0;
      branch_taken_q  <= 1'b0;
      branch_target_q <= alu_ext_pkg::DATA_RST;
    end else begin
      branch_valid_q <= instr_valid && is_branch;
      // RULE14 equal redirects, RULE15 not-equal redirects
      branch_taken_q <= instr_valid && is_branch &&
                        (br_equal == (op_d == alu_ext_pkg::BRANCH_EQ_CONST));
      if (instr_valid && is_branch) begin
        branch_target_q <= pc + br_offset;
      end
    end
  end

  // ==========================================================
  // Checks
  // ==========================================================
  default clocking chk_clk @(posedge clock);
  endclocking
  default disable iff (sys_rst);

  // RULE1 register add arith
  add_reg_arith_a: assert property ( // RULE1
    instr_valid && is_acc && funct7[2:0] == 3'h0 |=> wb_valid_q &&
    wb_data_q == 32'($signed($past(rd_value) + $past(rs1_value)) >>> $past(rs2_value[4:0])))
    else $error("register add arithmetic shift wrong");

  // RULE5 register sub logical
  sub_reg_logic_a: assert property ( // RULE5
    instr_valid && is_acc && funct7[2:0] == 3'h5 |=>
    wb_data_q == ($past(rd_value) - $past(rs1_value)) >> $past(rs2_value[4:0]))
    else $error("register subtract logical shift wrong");

  // RULE7 zero amount rounding
  round_zero_a: assert property ( // RULE7
    instr_valid && is_acc && funct7[1] && rs2_value[4:0] == 5'h00 |=>
    wb_data_q == ($past(funct7[2]) ? $past(rd_value) - $past(rs1_value)
                                   : $past(rd_value) + $past(rs1_value)))
    else $error("zero amount rounding not plain");

  // RULE12 constant add round
  const_add_round_a: assert property ( // RULE12
    instr_valid && op_d == alu_ext_pkg::ADD_CONST_SHIFT && instr[31:30] == 2'h3 &&
    instr[29:25] == 5'h01 |=>
    wb_data_q == ($past(rs1_value) + $past(rs2_value) + 32'h1) >> 1)
    else $error("constant add rounding wrong");

  // RULE19 absolute value
  abs_value_a: assert property ( // RULE19
    instr_valid && op_d == alu_ext_pkg::ABSOLUTE_VALUE_OP |=>
    !wb_data_q[31] || wb_data_q == 32'h8000_0000)
    else $error("absolute value negative");

  // RULE21 register clip range
  clip_reg_a: assert property ( // RULE21
    instr_valid && op_d == alu_ext_pkg::SATURATE_SIGNED_REG && !rs2_value[31] |=>
    $signed(wb_data_q) <= $signed($past(rs2_value)) &&
    $signed(wb_data_q) >= -$signed($past(rs2_value)) - 1)
    else $error("signed register clip out of range");

  // RULE20 set less equal
  set_le_a: assert property ( // RULE20
    instr_valid && op_d == alu_ext_pkg::SET_LE_UNSIGNED |=>
    wb_data_q == {31'h0, $past(rs1_value) <= $past(rs2_value)})
    else $error("unsigned set less equal wrong");

  // RULE14 equal branch taken
  branch_eq_a: assert property ( // RULE14
    instr_valid && op_d == alu_ext_pkg::BRANCH_EQ_CONST |=> branch_valid_q &&
    branch_taken_q == ($past(rs1_value) == 32'($signed($past(instr[24:20])))) &&
    branch_target_q == $past(pc) + 32'($signed({$past(instr[31]), $past(instr[7]),
      $past(instr[30:25]), $past(instr[11:8]), 1'b0})))
    else $error("equal branch wrong");

  // RULE15 not-equal branch
  branch_ne_a: assert property ( // RULE15
    instr_valid && op_d == alu_ext_pkg::BRANCH_NE_CONST |=> !wb_valid_q &&
    branch_taken_q != ($past(rs1_value) == 32'($signed($past(instr[24:20])))))
    else $error("not-equal branch wrong");

  // RULE22 illegal writes nothing
  illegal_nowrite_a: assert property ( // RULE22
    illegal_q |-> !wb_valid_q && !branch_valid_q)
    else $error("illegal instruction wrote");

endmodule : alu_ext_unit

// ---- dv/reg_file_model.sv ----
// ==========================================================
// Register file seen by the unit
// ==========================================================
module reg_file_model (
  input  wire logic        clock,
  input  wire logic [31:0] instr,
  input  wire logic        wb_valid_q,
  input  wire logic [4:0]  wb_addr_q,
  input  wire logic [31:0] wb_data_q,
  output logic      [31:0] rs1_value,
  output logic      [31:0] rs2_value,
  output logic      [31:0] rd_value
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [31:0] regs [32];

  // Combinational reads, register zero always reads zero
  assign rs1_value = (instr[19:15] == 5'h00) ? 32'h0 : regs[instr[19:15]];
  assign rs2_value = (instr[24:20] == 5'h00) ? 32'h0 : regs[instr[24:20]];
  assign rd_value  = (instr[11:7] == 5'h00) ? 32'h0 : regs[instr[11:7]];

  // Write-back lands on the edge that samples the pulse, one edge after it rises
  always @(posedge clock) begin
    if (wb_valid_q && wb_addr_q != 5'h00) begin
      regs[wb_addr_q] <= wb_data_q;
    end
  end
endmodule : reg_file_model

// ---- dv/alu_ext_unit_tb.sv ----
module alu_ext_unit_tb;
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================
  // Signals and instances
  // ==========================================================
  logic        clock = 1'b0;
  logic        sys_rst = 1'b1;
  logic        instr_valid = 1'b0;
  logic [31:0] instr = 32'h0;
  logic [31:0] pc = 32'h0;
  logic [31:0] rs1_value, rs2_value, rd_value, wb_data_q, branch_target_q;
  logic        wb_valid_q, illegal_q, branch_valid_q, branch_taken_q;
  logic [4:0]  wb_addr_q;
  int          error_cnt = 0;
  int          total_checks = 0;
  // Operation code, operand field, expected result with rs1 = -5, rs2 = 3
  localparam logic [43:0] GEN [15] = '{
    {7'h28, 5'h0, 32'h5}, {7'h29, 5'h2, 32'h1}, {7'h2a, 5'h2, 32'h0},
    {7'h2b, 5'h2, 32'hfffffffb}, {7'h2c, 5'h2, 32'h3}, {7'h2d, 5'h2, 32'h3},
    {7'h2e, 5'h2, 32'hfffffffb}, {7'h2f, 5'h0, 32'hfffffffb}, {7'h30, 5'h0, 32'hfffb},
    {7'h31, 5'h0, 32'hfffffffb}, {7'h32, 5'h0, 32'hfb}, {7'h38, 5'h3, 32'hfffffffc},
    {7'h39, 5'h3, 32'h0}, {7'h3a, 5'h2, 32'hfffffffc}, {7'h3b, 5'h2, 32'h0}};

  always #25 clock = ~clock;

  alu_ext_unit dut_u (.clock(clock), .sys_rst(sys_rst), .instr_valid(instr_valid), .instr(instr),
    .pc(pc), .rs1_value(rs1_value), .rs2_value(rs2_value), .rd_value(rd_value),
    .wb_valid_q(wb_valid_q), .wb_addr_q(wb_addr_q), .wb_data_q(wb_data_q), .illegal_q(illegal_q),
    .branch_valid_q(branch_valid_q), .branch_taken_q(branch_taken_q), .branch_target_q(branch_target_q));

  reg_file_model rf_u (.clock(clock), .instr(instr), .wb_valid_q(wb_valid_q), .wb_addr_q(wb_addr_q),
    .wb_data_q(wb_data_q), .rs1_value(rs1_value), .rs2_value(rs2_value), .rd_value(rd_value));

  // ==========================================================
  // Helpers
  // ==========================================================
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t value got %h exp %h", $time, got, exp);
    end
  endtask : chk32

  task automatic chk1(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t flag got %b exp %b", $time, got, exp);
    end
  endtask : chk1

  // Reference: m = {sub, round, logical}
  function automatic logic [31:0] accx(input logic [31:0] a, input logic [31:0] b,
                                       input logic [2:0] m, input logic [4:0] s);
    logic [31:0] t;
    t = m[2] ? a - b : a + b;
    if (m[1] && s != 5'h00) begin
      t = t + (32'h1 << (s - 5'h1));
    end
    return m[0] ? t >> s : $unsigned($signed(t) >>> s);
  endfunction : accx

  // Idle cycle first so the last write-back cannot overwrite the preset
  task automatic exec(input logic [31:0] ins, input logic [31:0] a, input logic [31:0] b,
                      input logic [31:0] d);
    @(negedge clock);
    rf_u.regs[ins[11:7]] = d;
    rf_u.regs[ins[24:20]] = b;
    rf_u.regs[ins[19:15]] = a;
    instr = ins;
    instr_valid = 1'b1;
    @(negedge clock);
    instr_valid = 1'b0;
  endtask : exec

  // ==========================================================
  // Scenarios
  // ==========================================================
  task automatic t_acc;
    logic [31:0] w;
    logic [4:0]  s;
    for (int m = 0; m < 8; m++) begin
      for (int k = 0; k < 2; k++) begin
        s = 5'(k * 5);
        w = {4'h8, m[2:0], 5'd2, 5'd1, 3'h3, 5'd4, 7'h2b};
        exec(w, 32'h7, 32'hffffffe0 | 32'(s), 32'h80000010);
        chk1(wb_valid_q, 1'b1);
        chk32(wb_data_q, accx(32'h80000010, 32'h7, m[2:0], s));
        w = {m[1:0], s, 5'd2, 5'd1, (m[2] ? 3'h3 : 3'h2), 5'd4, 7'h5b};
        exec(w, 32'h80000010, 32'h7, 32'h0);
        chk32(wb_data_q, accx(32'h80000010, 32'h7, m[2:0], s));
      end
    end
  endtask : t_acc

  task automatic t_general;
    for (int i = 0; i < 15; i++) begin
      exec({GEN[i][43:37], GEN[i][36:32], 5'd1, 3'h3, 5'd4, 7'h2b}, 32'hfffffffb, 32'h3, 32'h0);
      chk32(wb_data_q, GEN[i][31:0]);
      chk32({27'h0, wb_addr_q}, 32'h4);
    end
    exec({7'h3b, 5'd2, 5'd1, 3'h3, 5'd4, 7'h2b}, 32'ha, 32'h3, 32'h0);
    chk32(wb_data_q, 32'h3);
  endtask : t_general

  task automatic t_illegal;
    exec({7'h20, 5'd2, 5'd1, 3'h3, 5'd4, 7'h2b}, 32'h1, 32'h1, 32'h0);
    chk1(illegal_q, 1'b1);
    chk1(wb_valid_q, 1'b0);
    exec({7'h28, 5'd2, 5'd1, 3'h3, 5'd4, 7'h2b}, 32'h1, 32'h1, 32'h0);
    chk1(illegal_q, 1'b1);
    exec({7'h28, 5'd0, 5'd1, 3'h3, 5'd4, 7'h33}, 32'h1, 32'h1, 32'h0);
    chk1(illegal_q | wb_valid_q, 1'b0);
  endtask : t_illegal

  // Offset -8 from 0x1000; constant 0x1d is -3 once sign-extended
  task automatic t_branch;
    logic [12:0] off;
    off = 13'h1ff8;
    pc = 32'h1000;
    for (int k = 0; k < 4; k++) begin
      exec({off[12], off[10:5], 5'h1d, 5'd1, (k[0] ? 3'h7 : 3'h6), off[4:1], off[11], 7'h0b},
           (k[1] ? 32'h1d : 32'hfffffffd), 32'h0, 32'h0);
      chk1(branch_valid_q, 1'b1);
      chk1(branch_taken_q, k[0] ^ ~k[1]);
      chk32(branch_target_q, 32'hff8);
      chk1(wb_valid_q, 1'b0);
    end
  endtask : t_branch

  task automatic results;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : results

  // ==========================================================
  // Main sequence and watchdog
  // ==========================================================
  initial begin
    repeat (20) @(negedge clock);
    sys_rst = 1'b0;
    @(negedge clock);
    chk1(wb_valid_q | illegal_q | branch_valid_q, 1'b0);
    t_acc();
    t_general();
    t_illegal();
    t_branch();
    results();
  end

  // Whole run needs about 131 cycles; some fifteen times that is a hang
  initial begin
    repeat (2000) @(posedge clock);
    error_cnt++;
    results();
  end
endmodule : alu_ext_unit_tb
